// File: verilog/uie_irq_ctrl.sv
// usb function interrupt enables, pending flags and ahb-lite register slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module uie_irq_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_pkt_done,
    input wire logic rx_pkt_err,
    input wire logic [1:0] rx_ep,
    input wire logic tx_pkt_done,
    input wire logic tx_hs_ack,
    input wire logic [1:0] tx_ep,
    input wire logic ctrl_status_done,
    input wire logic ctrl_stall_sent,
    input wire logic ctrl_xfer_end,
    input wire logic frame_start_evt,
    input wire logic bus_reset_evt,
    input wire logic wakeup_evt,
    input wire logic sleep_evt,
    output logic hs_ack,
    output logic usb_irq
);
    uie_pkg::uie_regs_s r;
    uie_pkg::uie_regs_s next_r;
    logic take;
    logic rd;
    logic wr_now;
    logic csr_open;
    logic csr_wr;
    logic [7:0] aidx;
    logic [7:0] rd_val;
    logic [7:0] csr;
    logic good_rx;
    logic ep0_rx;
    logic ep0_tx;
    logic ep0_irq;
    logic [3:0] in_set;
    logic [3:0] out_set;
    logic [3:0] cm_set;
    logic clr_in;
    logic clr_out;
    logic clr_cm;

    // bus decode; hsize ignored since only whole words are used
    always_comb
    begin
        take = hsel & hready & htrans[1];
        aidx = uie_pkg::word_idx(haddr);
        rd = take & ~hwrite;
        wr_now = (r.phase == uie_pkg::BUS_DATA) & r.wr;
        csr_open = (r.ep_index == uie_pkg::CTRL_EP_INDEX);
        csr_wr = wr_now & (r.widx == uie_pkg::IDX_CTRL_EP_CONTROL_STATUS) & csr_open;
        clr_in = rd & (aidx == uie_pkg::IDX_IN_FLAG);
        clr_out = rd & (aidx == uie_pkg::IDX_OUT_FLAG);
        clr_cm = rd & (aidx == uie_pkg::IDX_CM_FLAG);
    end

    // packet events; bad packets never reach a flag
    always_comb
    begin
        good_rx = rx_pkt_done & ~rx_pkt_err;
        ep0_rx = good_rx & (rx_ep == 2'h0);
        ep0_tx = tx_pkt_done & tx_hs_ack & (tx_ep == 2'h0);
        out_set = 4'h0;
        in_set = 4'h0;
        for (int n = 1; n < 4; n++)
        begin
            out_set[n] = good_rx & (rx_ep == 2'(n));
            in_set[n] = tx_pkt_done & tx_hs_ack & (tx_ep == 2'(n));
        end
        in_set[0] = ep0_irq;
        cm_set = 4'h0;
        cm_set[uie_pkg::CM_SOF] = frame_start_evt;
        cm_set[uie_pkg::CM_RST] = bus_reset_evt;
        cm_set[uie_pkg::CM_RSU] = wakeup_evt;
        cm_set[uie_pkg::CM_SUS] = sleep_evt;
    end

    // read mux; unused upper bits come back as zero
    always_comb
    begin
        case (aidx)
            uie_pkg::IDX_IN_FLAG: rd_val = {4'h0, r.in_flag};
            uie_pkg::IDX_OUT_FLAG: rd_val = {4'h0, r.out_flag};
            uie_pkg::IDX_CM_FLAG: rd_val = {4'h0, r.cm_flag};
            uie_pkg::IDX_IN_IE: rd_val = {4'h0, r.in_ie};
            uie_pkg::IDX_OUT_IE: rd_val = {4'h0, r.out_ie};
            uie_pkg::IDX_CM_IE: rd_val = {4'h0, r.cm_ie};
            uie_pkg::IDX_INDEX: rd_val = {4'h0, r.ep_index};
            uie_pkg::IDX_CTRL_EP_CONTROL_STATUS: rd_val = csr_open ? csr : 8'h00;
            default: rd_val = 8'h00;
        endcase
    end

    // next state: bus phase, enable writes, flags with set winning over clear
    always_comb
    begin
        next_r = r;
        next_r.phase = take ? uie_pkg::BUS_DATA : uie_pkg::BUS_ADDR;
        if (take)
        begin
            next_r.wr = hwrite;
            next_r.widx = aidx;
        end
        if (rd)
            next_r.rdata = {24'h000000, rd_val};
        if (wr_now)
        begin
            case (r.widx)
                uie_pkg::IDX_IN_IE: next_r.in_ie = hwdata[3:0];
                uie_pkg::IDX_OUT_IE: next_r.out_ie = {hwdata[3:1], 1'b0};
                uie_pkg::IDX_CM_IE: next_r.cm_ie = hwdata[3:0];
                uie_pkg::IDX_INDEX: next_r.ep_index = hwdata[3:0];
                default: next_r.ep_index = r.ep_index;
            endcase
        end
        next_r.in_flag = (r.in_flag & ~{4{clr_in}}) | in_set;
        next_r.out_flag = (r.out_flag & ~{4{clr_out}}) | out_set;
        next_r.cm_flag = (r.cm_flag & ~{4{clr_cm}}) | cm_set;
    end

    // reset values come from the package constant
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r <= uie_pkg::REGS_RST;
        else
            r <= next_r;
    end

    // control endpoint causes, gated onto in flag bit 0
    uie_ep0_events u_ep0 (
        .hclk(hclk),
        .hresetn(hresetn),
        .rx_ok(ep0_rx),
        .tx_ok(ep0_tx),
        .status_done(ctrl_status_done),
        .stall_sent(ctrl_stall_sent),
        .xfer_end(ctrl_xfer_end),
        .wr_stb(csr_wr),
        .wr_data(hwdata[7:0]),
        .csr(csr),
        .irq(ep0_irq)
    );

    // zero wait state slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    // handshake decided here, no software in the loop
    assign hs_ack = good_rx;
    // disabled flags still sit in the register, they just do not drive the line
    assign usb_irq = |(r.in_flag & r.in_ie) | |(r.out_flag & r.out_ie) | |(r.cm_flag & r.cm_ie);

    in_ie_rst_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> (r.in_ie == 4'hF)) else $error("in enable reset value wrong");
    out_ie_rst_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> (r.out_ie == 4'hE)) else $error("out enable reset value wrong");
    sof_off_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> !r.cm_ie[uie_pkg::CM_SOF]) else $error("frame start enabled at reset");
    cm_rst_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> (r.cm_ie == 4'h6)) else $error("common enable reset value wrong");
    upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (r.phase == uie_pkg::BUS_DATA && !r.wr && r.widx != uie_pkg::IDX_CTRL_EP_CONTROL_STATUS) |-> (hrdata[31:4] == 28'h0000000))
        else $error("upper read bits not zero");
    ack_good_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hs_ack |-> (rx_pkt_done && !rx_pkt_err)) else $error("handshake on bad packet");
    rx_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (good_rx && rx_ep != 2'h0) |=> r.out_flag[$past(rx_ep)]) else $error("out flag not set");
    tx_noack_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_pkt_done && !tx_hs_ack && tx_ep != 2'h0 && r.in_flag == 4'h0) |=> (r.in_flag[3:1] == 3'h0))
        else $error("in flag without handshake");
    bad_rx_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_pkt_done && rx_pkt_err) |=> ((r.out_flag & ~$past(r.out_flag)) == 4'h0))
        else $error("flag set by corrupted packet");
    csr_hidden_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd && aidx == uie_pkg::IDX_CTRL_EP_CONTROL_STATUS && r.ep_index != 4'h0) |=> (hrdata == 32'h00000000))
        else $error("control status visible at nonzero index");
    ep0_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ep0_rx && !clr_in) |=> ##1 r.in_flag[0]) else $error("endpoint 0 flag not set");
    irq_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
        usb_irq |-> (|(r.in_flag & r.in_ie) || |(r.out_flag & r.out_ie) || |(r.cm_flag & r.cm_ie)))
        else $error("request without enabled flag");
    read_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        clr_cm |=> (r.cm_flag == $past(cm_set))) else $error("common flags not cleared by read");
    sof_pos_a: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_start_evt |=> r.cm_flag[3]) else $error("frame start flag misplaced");
    masked_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (sleep_evt && !r.cm_ie[0] && r.cm_flag == 4'h0 && r.cm_ie[3:1] == 3'h0 && !clr_cm && !rd)
        |=> (r.cm_flag[0] && !(|(r.cm_flag & r.cm_ie)))) else $error("masked flag lost or gating");
    ie_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && r.widx == uie_pkg::IDX_IN_IE) |=> (r.in_ie == $past(hwdata[3:0])))
        else $error("in enable write not taken");

    // out enable bit 0 has no endpoint behind it
    out_bit0_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !r.out_ie[0])
        else $error("out enable bit 0 set");

    // out enable write keeps bit 0 clear
    out_ie_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && r.widx == uie_pkg::IDX_OUT_IE) |=> (r.out_ie == {$past(hwdata[3:1]), 1'b0}))
        else $error("out enable write not taken");

    // common enable write lands whole
    cm_ie_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && r.widx == uie_pkg::IDX_CM_IE) |=> (r.cm_ie == $past(hwdata[3:0])))
        else $error("common enable write not taken");

    // index register gates the control status access
    index_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && r.widx == uie_pkg::IDX_INDEX) |=> (r.ep_index == $past(hwdata[3:0])))
        else $error("index write not taken");

    // control status visible with index zero
    csr_visible_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd && aidx == uie_pkg::IDX_CTRL_EP_CONTROL_STATUS && r.ep_index == 4'h0) |=> (hrdata == {24'h000000, $past(csr)}))
        else $error("control status not readable");

    // every good packet gets its handshake
    good_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_pkt_done && !rx_pkt_err) |-> hs_ack)
        else $error("no handshake on good packet");

    // acknowledged in packet sets its flag
    tx_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_pkt_done && tx_hs_ack && tx_ep != 2'h0) |=> r.in_flag[$past(tx_ep)])
        else $error("in flag not set");

    // read clears in flags, a same cycle set survives
    in_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        clr_in |=> (r.in_flag == $past(in_set)))
        else $error("in flags not cleared by read");

    // read clears out flags, a same cycle set survives
    out_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        clr_out |=> (r.out_flag == $past(out_set)))
        else $error("out flags not cleared by read");

    // without a read no common flag is lost
    flag_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !clr_cm |=> ((r.cm_flag & $past(r.cm_flag)) == $past(r.cm_flag)))
        else $error("common flag lost");

    // an enabled pending out flag drives the request
    irq_enabled_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (|(r.out_flag & r.out_ie)) |-> usb_irq)
        else $error("request missing");

    // common flags read back as recorded
    cm_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd && aidx == uie_pkg::IDX_CM_FLAG) |=> (hrdata == {28'h0000000, $past(r.cm_flag)}))
        else $error("common flags read wrong");

    // bus reset flag position
    rst_pos_a: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_reset_evt |=> r.cm_flag[2])
        else $error("bus reset flag misplaced");

    // wakeup flag position
    wake_pos_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wakeup_evt |=> r.cm_flag[1])
        else $error("wakeup flag misplaced");

    // sleep flag position
    sleep_pos_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sleep_evt |=> r.cm_flag[0])
        else $error("sleep flag misplaced");

    // reset leaves index zero and no pending in or common flag
    state_rst_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> (r.ep_index == 4'h0 && r.in_flag == 4'h0 && r.cm_flag == 4'h0))
        else $error("index or flags not reset");

    // zero wait, always okay, so the master never stalls
    bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hreadyout && !hresp))
        else $error("bus not ready or not okay");
endmodule : uie_irq_ctrl
`default_nettype wire

// File: verilog/uie_pkg.sv
// constants, state layouts and helpers shared by the usb interrupt enable block
`default_nettype none
package uie_pkg;
    // register word indices; byte address is four times the index
    localparam logic [7:0] IDX_IN_FLAG = 8'h02;
    localparam logic [7:0] IDX_OUT_FLAG = 8'h04;
    localparam logic [7:0] IDX_CM_FLAG = 8'h06;
    localparam logic [7:0] IDX_IN_IE = 8'h07;
    localparam logic [7:0] IDX_OUT_IE = 8'h09;
    localparam logic [7:0] IDX_CM_IE = 8'h0B;
    localparam logic [7:0] IDX_INDEX = 8'h0E;
    localparam logic [7:0] IDX_CTRL_EP_CONTROL_STATUS = 8'h11;
    // values after reset
    localparam logic [3:0] IN_IE_RST = 4'hF;
    localparam logic [3:0] OUT_IE_RST = 4'hE;
    localparam logic [3:0] CM_IE_RST = 4'h6;
    localparam logic [3:0] CTRL_EP_INDEX = 4'h0;
    // common flag and enable bit positions
    localparam int CM_SOF = 3;
    localparam int CM_RST = 2;
    localparam int CM_RSU = 1;
    localparam int CM_SUS = 0;
    // control endpoint status bit positions
    localparam int CSR_OPR = 0;
    localparam int CSR_IPR = 1;
    localparam int CSR_STL = 2;
    localparam int CSR_DEND = 3;
    localparam int CSR_SEND = 4;
    localparam int CSR_SDSTL = 5;
    localparam int CSR_SOPR = 6;
    localparam int CSR_SSEND = 7;
    // bus slave phase
    typedef enum logic [1:0] {BUS_ADDR = 2'b01, BUS_DATA = 2'b10} uie_bus_e;
    typedef struct packed {
        uie_bus_e phase;
        logic wr;
        logic [7:0] widx;
        logic [3:0] in_ie;
        logic [3:0] out_ie;
        logic [3:0] cm_ie;
        logic [3:0] ep_index;
        logic [3:0] in_flag;
        logic [3:0] out_flag;
        logic [3:0] cm_flag;
        logic [31:0] rdata;
    } uie_regs_s;
    localparam uie_regs_s REGS_RST = '{BUS_ADDR, 1'b0, 8'h00, IN_IE_RST, OUT_IE_RST, CM_IE_RST,
                                       4'h0, 4'h0, 4'h0, 4'h0, 32'h00000000};
    typedef struct packed {
        logic out_packet_ready;
        logic in_packet_ready;
        logic sent_stall;
        logic data_end_a;
        logic setup_end;
        logic send_stall;
        logic irq;
    } uie_ep0_s;
    localparam uie_ep0_s EP0_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    // byte address to register word index
    function automatic logic [7:0] word_idx(input logic [31:0] a);
        return a[9:2];
    endfunction : word_idx
endpackage : uie_pkg
`default_nettype wire

// File: verilog/uie_ep0_events.sv
// control endpoint status bits and its interrupt causes
`timescale 1ns/1ps
`default_nettype none
module uie_ep0_events (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic rx_ok,
    input wire logic tx_ok,
    input wire logic status_done,
    input wire logic stall_sent,
    input wire logic xfer_end,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    output logic [7:0] csr,
    output logic irq
);
    uie_pkg::uie_ep0_s s;
    uie_pkg::uie_ep0_s next_s;

    // software writes first, hardware events after so a hardware event wins
    always_comb
    begin
        next_s = s;
        next_s.irq = 1'b0;
        if (wr_stb)
        begin
            if (wr_data[uie_pkg::CSR_SSEND])
                next_s.setup_end = 1'b0;
            if (wr_data[uie_pkg::CSR_SOPR])
                next_s.out_packet_ready = 1'b0;
            if (!wr_data[uie_pkg::CSR_STL])
                next_s.sent_stall = 1'b0;
            if (wr_data[uie_pkg::CSR_SDSTL])
                next_s.send_stall = 1'b1;
            if (wr_data[uie_pkg::CSR_DEND])
                next_s.data_end_a = 1'b1;
            if (wr_data[uie_pkg::CSR_IPR])
                next_s.in_packet_ready = 1'b1;
        end
        // setup or out packet stored; a pending in packet is overwritten
        if (rx_ok)
        begin
            next_s.out_packet_ready = 1'b1;
            next_s.in_packet_ready = 1'b0;
            next_s.irq = 1'b1;
        end
        if (tx_ok)
        begin
            next_s.in_packet_ready = 1'b0;
            next_s.irq = 1'b1;
        end
        if (status_done)
        begin
            next_s.data_end_a = 1'b0;
            next_s.irq = 1'b1;
        end
        if (stall_sent)
        begin
            next_s.sent_stall = 1'b1;
            next_s.send_stall = 1'b0;
            next_s.irq = 1'b1;
        end
        // premature end only counts while data end is still clear
        if (xfer_end)
        begin
            next_s.data_end_a = 1'b0;
            if (!s.data_end_a)
            begin
                next_s.setup_end = 1'b1;
                next_s.irq = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= uie_pkg::EP0_RST;
        else
            s <= next_s;
    end

    // serviced bits always read zero
    assign csr = {2'b00, s.send_stall, s.setup_end, s.data_end_a, s.sent_stall, s.in_packet_ready,
                  s.out_packet_ready};
    assign irq = s.irq;

    rx_sets_opr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_ok |=> (s.out_packet_ready && irq)) else $error("out packet ready or irq missing");
    tx_clears_ipr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_ok && !wr_stb) |=> (!s.in_packet_ready && irq)) else $error("in packet ready not cleared");
    status_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        status_done |=> irq) else $error("no irq after status stage");
    stall_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stall_sent |=> (s.sent_stall && !s.send_stall && irq)) else $error("sent stall not set");
    setup_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (xfer_end && !s.data_end_a) |=> (s.setup_end && irq)) else $error("setup end not set");
endmodule : uie_ep0_events
`default_nettype wire

// File: bench/uie_host_model.sv
// event source standing in for the usb serial engine and the host traffic it sees
`timescale 1ns/1ps
`default_nettype none
module uie_host_model (
    input wire logic hclk,
    input wire logic hs_ack,
    output logic rx_pkt_done,
    output logic rx_pkt_err,
    output logic [1:0] rx_ep,
    output logic tx_pkt_done,
    output logic tx_hs_ack,
    output logic [1:0] tx_ep,
    output logic ctrl_status_done,
    output logic ctrl_stall_sent,
    output logic ctrl_xfer_end,
    output logic frame_start_evt,
    output logic bus_reset_evt,
    output logic wakeup_evt,
    output logic sleep_evt
);
    logic [8:0] pend = 9'h000;
    logic [1:0] ep_q = 2'h0;
    logic q_q = 1'b0;
    // one-hot pulse vector fans out to the separate event ports
    assign rx_pkt_done = pend[0];
    assign tx_pkt_done = pend[1];
    assign ctrl_status_done = pend[2];
    assign ctrl_stall_sent = pend[3];
    assign ctrl_xfer_end = pend[4];
    assign frame_start_evt = pend[5];
    assign bus_reset_evt = pend[6];
    assign wakeup_evt = pend[7];
    assign sleep_evt = pend[8];
    // qualifiers are meaningless outside a pulse, so they show the inverse then
    assign rx_ep = ep_q;
    assign tx_ep = ep_q;
    assign rx_pkt_err = q_q;
    assign tx_hs_ack = q_q;
    // pulse one event for a cycle; ack returns the handshake seen meanwhile
    task automatic ev(input int kind, input logic [1:0] ep, input logic q, output logic ack);
        @(posedge hclk);
        pend <= 9'h001 << kind;
        ep_q <= ep;
        q_q <= q;
        #1 ack = hs_ack;
        @(posedge hclk);
        pend <= 9'h000;
        ep_q <= ~ep;
        q_q <= ~q;
    endtask : ev
endmodule : uie_host_model
`default_nettype wire

// File: bench/tb_uie_irq_ctrl.sv
// self-checking bench for the usb interrupt enables and event flags
`timescale 1ns/1ps
`default_nettype none
module tb_uie_irq_ctrl;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hs_ack, usb_irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic rx_pkt_done, rx_pkt_err, tx_pkt_done, tx_hs_ack, ctrl_status_done, ctrl_stall_sent;
    wire logic ctrl_xfer_end, frame_start_evt, bus_reset_evt, wakeup_evt, sleep_evt;
    wire logic [1:0] rx_ep, tx_ep;
    int err_total, cmp_count;
    uie_irq_ctrl uie_irq_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_pkt_done(rx_pkt_done),
        .rx_pkt_err(rx_pkt_err), .rx_ep(rx_ep), .tx_pkt_done(tx_pkt_done), .tx_hs_ack(tx_hs_ack),
        .tx_ep(tx_ep), .ctrl_status_done(ctrl_status_done), .ctrl_stall_sent(ctrl_stall_sent),
        .ctrl_xfer_end(ctrl_xfer_end), .frame_start_evt(frame_start_evt), .bus_reset_evt(bus_reset_evt),
        .wakeup_evt(wakeup_evt), .sleep_evt(sleep_evt), .hs_ack(hs_ack), .usb_irq(usb_irq));
    uie_host_model uie_host_model_inst (.hclk(hclk), .hs_ack(hs_ack), .rx_pkt_done(rx_pkt_done),
        .rx_pkt_err(rx_pkt_err), .rx_ep(rx_ep), .tx_pkt_done(tx_pkt_done), .tx_hs_ack(tx_hs_ack),
        .tx_ep(tx_ep), .ctrl_status_done(ctrl_status_done), .ctrl_stall_sent(ctrl_stall_sent),
        .ctrl_xfer_end(ctrl_xfer_end), .frame_start_evt(frame_start_evt), .bus_reset_evt(bus_reset_evt),
        .wakeup_evt(wakeup_evt), .sleep_evt(sleep_evt));
    // 20 MHz bus clock
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // bounded wait for hready at the next rising edges
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                check("bus wait", 32'h1, 32'h0);
                print_verdict();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    // one single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check("okay response", {31'h0, hresp}, 32'h0);
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0, x);
        check(what, x, exp);
    endtask : rd_chk
    // expected pending pattern of one endpoint event
    function automatic logic [3:0] flag_of(input int ep, input logic ok);
        return ok ? 4'h1 << ep : 4'h0;
    endfunction : flag_of
    // control endpoint event, then its status bits and the pending bit 0
    task automatic ep0_step(input int kind, input logic [31:0] csr_exp);
        logic a;
        uie_host_model_inst.ev(kind, 2'h0, kind == 1, a);
        rd_chk("ctrl status", uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, csr_exp);
        rd_chk("ctrl pending", uie_pkg::IDX_IN_FLAG, 32'h1);
    endtask : ep0_step
    initial
    begin
        logic [7:0] idx_t [3];
        logic [3:0] mask_t [3];
        logic [3:0] rst_t [3];
        logic [31:0] v;
        logic [3:0] en, fl;
        logic ack, q;
        int k, ep;
        idx_t = '{uie_pkg::IDX_IN_IE, uie_pkg::IDX_OUT_IE, uie_pkg::IDX_CM_IE};
        mask_t = '{4'hF, 4'hE, 4'hF};
        rst_t = '{4'hF, 4'hE, 4'h6};
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_total = 0;
        cmp_count = 0;
        v = $urandom(32'hDFFC4CCF);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, then random writes, then a second reset mid-run
        for (int r = 0; r < 2; r++)
        begin
            for (int i = 0; i < 3; i++)
                rd_chk("enable reset", idx_t[i], {28'h0, rst_t[i]});
            for (int i = 0; i < 12 && r == 0; i++)
            begin
                k = (i < 3) ? i : $urandom_range(2);
                v = (i < 3) ? 32'hFFFFFFFF : $urandom;
                wr(idx_t[k], v);
                rd_chk("enable readback", idx_t[k], v & {28'h0, mask_t[k]});
            end
            @(posedge hclk);
            hresetn <= r[0];
            repeat (2) @(posedge hclk);
            hresetn <= 1'b1;
        end
        $display("test enable registers done");
        // endpoint 1-3 packets, good and bad, enabled or masked
        for (int i = 0; i < 16; i++)
        begin
            en = 4'($urandom);
            ep = $urandom_range(3, 1);
            k = $urandom_range(1);
            q = (i < 2) ? i[0] : ($urandom_range(3) != 0);
            wr(k ? uie_pkg::IDX_IN_IE : uie_pkg::IDX_OUT_IE, {28'h0, en});
            uie_host_model_inst.ev(k, ep[1:0], k ? q : ~q, ack);
            if (k == 0) check("handshake", {31'h0, ack}, {31'h0, q});
            fl = flag_of(ep, q);
            @(negedge hclk);
            check("irq on packet", {31'h0, usb_irq}, {31'h0, |(fl & en)});
            v = {24'h0, k ? uie_pkg::IDX_IN_FLAG : uie_pkg::IDX_OUT_FLAG};
            rd_chk("endpoint pending", v[7:0], {28'h0, fl});
            rd_chk("pending after read", v[7:0], 32'h0);
            check("irq after read", {31'h0, usb_irq}, 32'h0);
        end
        $display("test endpoint events done");
        // common events recorded while masked, raise the request once enabled
        for (int b = 0; b < 4; b++)
        begin
            wr(uie_pkg::IDX_CM_IE, 32'h0);
            uie_host_model_inst.ev(8 - b, 2'h0, 1'b0, ack);
            @(negedge hclk);
            check("common masked", {31'h0, usb_irq}, 32'h0);
            wr(uie_pkg::IDX_CM_IE, 32'h1 << b);
            @(negedge hclk);
            check("common enabled", {31'h0, usb_irq}, 32'h1);
            rd_chk("common pending", uie_pkg::IDX_CM_FLAG, 32'h1 << b);
        end
        $display("test common events done");
        // control endpoint causes, reachable only with index zero
        wr(uie_pkg::IDX_INDEX, 32'h3);
        wr(uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h02);
        rd_chk("ctrl hidden", uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h0);
        wr(uie_pkg::IDX_INDEX, 32'h0);
        rd_chk("ctrl write ignored", uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h0);
        ep0_step(0, 32'h01);
        wr(uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h42);
        rd_chk("ctrl in ready", uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h02);
        ep0_step(1, 32'h00);
        ep0_step(2, 32'h00);
        ep0_step(3, 32'h04);
        wr(uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h00);
        rd_chk("stall cleared", uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h00);
        ep0_step(4, 32'h10);
        wr(uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h80);
        wr(uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h08);
        uie_host_model_inst.ev(4, 2'h0, 1'b0, ack);
        rd_chk("end with data end", uie_pkg::IDX_CTRL_EP_CONTROL_STATUS, 32'h00);
        $display("test control endpoint done");
        print_verdict();
    end
endmodule : tb_uie_irq_ctrl
`default_nettype wire
